// file: pkg/tstp_pkg.sv
// Purpose: Shared constants and types for the trigger start pulse timer.
// Assumes: A single 100 MHz system clock.
// Notes: Register indices are word indices; byte address is four times the index.
package tstp_pkg;

  localparam int unsigned TSTP_PRESC_W = 13;
  localparam real TSTP_CLK_PERIOD_NS = 10.0;

  // Register word indices.
  localparam logic [15:0] TSTP_IDX_CTL0 = 16'hffa0;
  localparam logic [15:0] TSTP_IDX_STAT = 16'hffa1;
  localparam logic [15:0] TSTP_IDX_CORA = 16'hffa2;
  localparam logic [15:0] TSTP_IDX_CORB = 16'hffa3;
  localparam logic [15:0] TSTP_IDX_CNT = 16'hffa4;
  localparam logic [15:0] TSTP_IDX_CTL1 = 16'hffa5;
  localparam logic [15:0] TSTP_IDX_PORT = 16'hffe0;

  // Reset values.
  localparam logic [7:0] TSTP_CTL0_RST = 8'h00;
  localparam logic [7:0] TSTP_CTL1_RST = 8'h00;
  localparam logic [7:0] TSTP_STAT_RST = 8'h00;
  localparam logic [7:0] TSTP_CORA_RST = 8'hff;
  localparam logic [7:0] TSTP_CORB_RST = 8'hff;
  localparam logic [7:0] TSTP_CNT_RST = 8'h00;
  localparam logic [7:0] TSTP_PORT_RST = 8'h00;

  // Writable bit masks.
  localparam logic [7:0] TSTP_CTL1_WMASK = 8'h1d;
  localparam logic [7:0] TSTP_STAT_WMASK = 8'h0f;

  // Field positions.
  localparam int unsigned TSTP_PORT_TRIG_BIT = 7;
  localparam int unsigned TSTP_FLAG_B_BIT = 7;
  localparam int unsigned TSTP_FLAG_A_BIT = 6;
  localparam int unsigned TSTP_FLAG_OVF_BIT = 5;

  // Smallest internal divisor as a power of two.
  localparam int unsigned TSTP_DIV_BASE_LOG2 = 2;
  localparam int unsigned TSTP_NUM_DIVS = 6;

  typedef enum logic [1:0] {
    TSTP_CCLR_NONE = 2'b00,
    TSTP_CCLR_ON_A = 2'b01,
    TSTP_CCLR_ON_B = 2'b10,
    TSTP_CCLR_ON_TRIG = 2'b11
  } tstp_cclr_t;

  typedef enum logic [1:0] {
    TSTP_EDGE_OFF = 2'b00,
    TSTP_EDGE_RISE = 2'b01,
    TSTP_EDGE_FALL = 2'b10,
    TSTP_EDGE_BOTH = 2'b11
  } tstp_edge_t;

  typedef enum logic [1:0] {
    TSTP_OS_KEEP = 2'b00,
    TSTP_OS_LOW = 2'b01,
    TSTP_OS_HIGH = 2'b10,
    TSTP_OS_TOGGLE = 2'b11
  } tstp_os_t;

  typedef struct packed {
    logic ie_b;
    logic ie_a;
    logic ie_ovf;
    tstp_cclr_t cclr;
    logic [2:0] cks;
  } tstp_ctl0_t;

  typedef struct packed {
    logic [2:0] rsv_hi;
    tstp_edge_t edge_sel;
    logic trig_en;
    logic rsv_lo;
    logic icks0;
  } tstp_ctl1_t;

  typedef struct packed {
    logic [2:0] cks;
    logic icks0;
  } tstp_clk_sel_t;

endpackage : tstp_pkg

// file: hw/tstp_edge_sync.sv
// Purpose: Two-stage synchroniser with rising and falling edge pulses.
// Assumes: Pin is asynchronous to hclk.
// Notes: Edge pulses last one hclk cycle.
`timescale 1ns/1ps
`default_nettype none
module tstp_edge_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_in,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
endmodule : tstp_edge_sync
`default_nettype wire

// file: hw/tstp_prescaler.sv
// Purpose: Free-running prescaler and counter clock source selection.
// Assumes: External clock edges arrive already synchronised.
// Notes: Tick is a one-cycle strobe at the selected rate.
`timescale 1ns/1ps
`default_nettype none
module tstp_prescaler
  import tstp_pkg::*;
#(
  parameter int unsigned PRESC_W = TSTP_PRESC_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire tstp_clk_sel_t sel,
  input wire logic ext_rise,
  input wire logic ext_fall,
  output logic tick
);
  logic [PRESC_W-1:0] pss_reg;
  logic [TSTP_NUM_DIVS-1:0] div_tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pss_reg <= '0;
    end else begin
      pss_reg <= pss_reg + {{(PRESC_W-1){1'b0}}, 1'b1};
    end
  end

  // Divide by 2^(i+2): strobe when the low bits are all ones.
  for (genvar i = 0; i < TSTP_NUM_DIVS; i++) begin : g_div
    assign div_tick[i] = &pss_reg[i+TSTP_DIV_BASE_LOG2-1:0];
  end

  always_comb begin
    unique case (sel.cks)
      3'h1: tick = sel.icks0 ? div_tick[1] : div_tick[0];
      3'h2: tick = sel.icks0 ? div_tick[3] : div_tick[2];
      3'h3: tick = sel.icks0 ? div_tick[5] : div_tick[4];
      3'h5: tick = ext_rise;
      3'h6: tick = ext_fall;
      3'h7: tick = ext_rise | ext_fall;
      default: tick = 1'b0;
    endcase
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_presc_steps: assert property ($past(hresetn) |-> pss_reg == $past(pss_reg) + 1'b1)
    else $error("prescaler did not advance by one");
  a_div64_tick: assert property (sel.cks == 3'h3 && !sel.icks0 && tick |-> pss_reg[5:0] == 6'h3f)
    else $error("divide by 64 tick at wrong prescaler phase");
endmodule : tstp_prescaler
`default_nettype wire

// file: hw/tstp_top.sv
// Purpose: Trigger started 8-bit pulse timer with an AHB-Lite register slave.
// Assumes: Single-word AHB-Lite transfers; zero wait states.
// Notes: Trigger and external clock pins are synchronised before use.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - A 13-bit prescaler advances every system clock and feeds divided clocks.
// - Counter is 8-bit read/write up-counter; nine clock sources, six internal, three external.
// - Control zero picks counter clock and the counter clearing condition.
// - Control one picks trigger edge, start-on-trigger, halt on clear, clock share.
// - Constant A is always compared with the counter; equality raises match A.
// - Equality with constant B raises match B; with that clear mode counter goes zero.
// - Status register sets pin level on matches; 0x16 gives high at A, low at B.
// - Control zero 0x13: interrupts off, clear on B, clock divided by 64.
// - Control one 0xF6: falling trigger, start on trigger and halt on clear, divide 64 kept.
// - Port select bit 7 set routes shared pin to the trigger function.
// - Match A occurs exactly when counter reaches the constant A value.
module tstp_top
  import tstp_pkg::*;
#(
  parameter int unsigned PRESC_W = TSTP_PRESC_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic trigger_in_pin,
  input wire logic ext_clk_pin,
  output logic pulse_out_pin
);

  tstp_ctl0_t ctl0_reg;
  tstp_ctl1_t ctl1_reg;
  logic [7:0] cora_reg;
  logic [7:0] corb_reg;
  logic [7:0] cnt_reg;
  logic [7:0] port_reg;
  logic [3:0] os_reg;
  logic match_b_flag;
  logic match_a_flag;
  logic overflow_flag;
  logic run_reg;
  logic eq_a_prev_reg;
  logic eq_b_prev_reg;
  logic pulse_reg;
  logic [31:0] hrdata_reg;
  logic wr_pend_reg;
  logic [15:0] idx_reg;

  logic trig_rise;
  logic trig_fall;
  logic ext_rise;
  logic ext_fall;
  logic tick;
  tstp_clk_sel_t clk_sel;

  logic addr_ok;
  logic take;
  logic [15:0] idx_in;
  logic wr_ctl0;
  logic wr_ctl1;
  logic wr_stat;
  logic wr_cora;
  logic wr_corb;
  logic wr_cnt;
  logic wr_port;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  logic trig_evt;
  logic match_a;
  logic match_b;
  logic clr_by_match;
  logic clr_evt;
  logic running;
  logic cnt_inc;
  tstp_os_t os_a;
  tstp_os_t os_b;

  // Pin synchronisers.
  tstp_edge_sync u_trig_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(trigger_in_pin),
    .rise(trig_rise),
    .fall(trig_fall)
  );

  tstp_edge_sync u_ext_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(ext_clk_pin),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  assign clk_sel = '{cks: ctl0_reg.cks, icks0: ctl1_reg.icks0};

  tstp_prescaler #(
    .PRESC_W(PRESC_W)
  ) u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .sel(clk_sel),
    .ext_rise(ext_rise),
    .ext_fall(ext_fall),
    .tick(tick)
  );

  // AHB-Lite address phase decode.
  assign idx_in = haddr[17:2];
  assign addr_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00) && (hsize == 3'b010);
  assign take = hsel && htrans[1] && hready && addr_ok;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      idx_reg <= 16'h0000;
    end else if (hready) begin
      wr_pend_reg <= take && hwrite;
      idx_reg <= idx_in;
    end
  end

  assign wbyte = hwdata[7:0];
  assign wr_ctl0 = wr_pend_reg && (idx_reg == TSTP_IDX_CTL0);
  assign wr_ctl1 = wr_pend_reg && (idx_reg == TSTP_IDX_CTL1);
  assign wr_stat = wr_pend_reg && (idx_reg == TSTP_IDX_STAT);
  assign wr_cora = wr_pend_reg && (idx_reg == TSTP_IDX_CORA);
  assign wr_corb = wr_pend_reg && (idx_reg == TSTP_IDX_CORB);
  assign wr_cnt = wr_pend_reg && (idx_reg == TSTP_IDX_CNT);
  assign wr_port = wr_pend_reg && (idx_reg == TSTP_IDX_PORT);

  always_comb begin
    unique case (idx_in)
      TSTP_IDX_CTL0: rd_byte = ctl0_reg;
      TSTP_IDX_STAT: rd_byte = {match_b_flag, match_a_flag, overflow_flag, 1'b0, os_reg};
      TSTP_IDX_CORA: rd_byte = cora_reg;
      TSTP_IDX_CORB: rd_byte = corb_reg;
      TSTP_IDX_CNT: rd_byte = cnt_reg;
      TSTP_IDX_CTL1: rd_byte = ctl1_reg;
      TSTP_IDX_PORT: rd_byte = port_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // Control and constant registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl0_reg <= TSTP_CTL0_RST;
      ctl1_reg <= TSTP_CTL1_RST;
      cora_reg <= TSTP_CORA_RST;
      corb_reg <= TSTP_CORB_RST;
      port_reg <= TSTP_PORT_RST;
      os_reg <= TSTP_STAT_RST[3:0];
    end else begin
      if (wr_ctl0) begin
        ctl0_reg <= wbyte;
      end
      if (wr_ctl1) begin
        ctl1_reg <= wbyte & TSTP_CTL1_WMASK;
      end
      if (wr_cora) begin
        cora_reg <= wbyte;
      end
      if (wr_corb) begin
        corb_reg <= wbyte;
      end
      if (wr_port) begin
        port_reg <= wbyte;
      end
      if (wr_stat) begin
        os_reg <= wbyte[3:0] & TSTP_STAT_WMASK[3:0];
      end
    end
  end

  // Trigger is seen only when the shared pin is given to the timer.
  always_comb begin
    trig_evt = 1'b0;
    if (port_reg[TSTP_PORT_TRIG_BIT]) begin
      unique case (ctl1_reg.edge_sel)
        TSTP_EDGE_RISE: trig_evt = trig_rise;
        TSTP_EDGE_FALL: trig_evt = trig_fall;
        TSTP_EDGE_BOTH: trig_evt = trig_rise | trig_fall;
        TSTP_EDGE_OFF: trig_evt = 1'b0;
      endcase
    end
  end

  // Matches fire once when the counter first takes the constant's value.
  assign match_a = (cnt_reg == cora_reg) && !eq_a_prev_reg;
  assign match_b = (cnt_reg == corb_reg) && !eq_b_prev_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eq_a_prev_reg <= 1'b1;
      eq_b_prev_reg <= 1'b1;
    end else begin
      eq_a_prev_reg <= cnt_reg == cora_reg;
      eq_b_prev_reg <= cnt_reg == corb_reg;
    end
  end

  assign clr_by_match = (ctl0_reg.cclr == TSTP_CCLR_ON_A && match_a)
                      || (ctl0_reg.cclr == TSTP_CCLR_ON_B && match_b);
  assign clr_evt = clr_by_match || (ctl0_reg.cclr == TSTP_CCLR_ON_TRIG && trig_evt);
  assign running = !ctl1_reg.trig_en || run_reg;
  assign cnt_inc = tick && running;

  // Run flag: a trigger starts counting, a clearing match halts it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= 1'b0;
    end else if (trig_evt) begin
      run_reg <= 1'b1;
    end else if (clr_by_match) begin
      run_reg <= 1'b0;
    end
  end

  // Counter: a bus write wins, then clearing, then counting.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= TSTP_CNT_RST;
    end else if (wr_cnt) begin
      cnt_reg <= wbyte;
    end else if (clr_evt) begin
      cnt_reg <= 8'h00;
    end else if (cnt_inc) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // Flags: hardware set wins over a software clear by writing zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_b_flag <= TSTP_STAT_RST[TSTP_FLAG_B_BIT];
      match_a_flag <= TSTP_STAT_RST[TSTP_FLAG_A_BIT];
      overflow_flag <= TSTP_STAT_RST[TSTP_FLAG_OVF_BIT];
    end else begin
      if (match_b) begin
        match_b_flag <= 1'b1;
      end else if (wr_stat && !wbyte[TSTP_FLAG_B_BIT]) begin
        match_b_flag <= 1'b0;
      end
      if (match_a) begin
        match_a_flag <= 1'b1;
      end else if (wr_stat && !wbyte[TSTP_FLAG_A_BIT]) begin
        match_a_flag <= 1'b0;
      end
      if (cnt_inc && cnt_reg == 8'hff && !clr_evt && !wr_cnt) begin
        overflow_flag <= 1'b1;
      end else if (wr_stat && !wbyte[TSTP_FLAG_OVF_BIT]) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // Output pin: a match B action other than keep takes priority over match A.
  assign os_a = tstp_os_t'(os_reg[1:0]);
  assign os_b = tstp_os_t'(os_reg[3:2]);

  function automatic logic os_apply(input logic cur, input tstp_os_t os);
    unique case (os)
      TSTP_OS_LOW: os_apply = 1'b0;
      TSTP_OS_HIGH: os_apply = 1'b1;
      TSTP_OS_TOGGLE: os_apply = ~cur;
      TSTP_OS_KEEP: os_apply = cur;
    endcase
  endfunction : os_apply

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_reg <= 1'b0;
    end else if (match_b && os_b != TSTP_OS_KEEP) begin
      pulse_reg <= os_apply(pulse_reg, os_b);
    end else if (match_a) begin
      pulse_reg <= os_apply(pulse_reg, os_a);
    end
  end

  assign pulse_out_pin = pulse_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_match_a_value: assert property (match_a |-> cnt_reg == cora_reg && !$past(cnt_reg == cora_reg))
    else $error("match A without fresh equality");
  a_match_a_seen: assert property ($rose(cnt_reg == cora_reg) |-> match_a)
    else $error("equality with constant A missed");
  a_clear_on_b: assert property (match_b && ctl0_reg.cclr == TSTP_CCLR_ON_B && !wr_cnt |=> cnt_reg == 8'h00)
    else $error("counter not cleared on match B");
  a_pin_high_a: assert property (match_a && os_a == TSTP_OS_HIGH && !(match_b && os_b != TSTP_OS_KEEP)
                                 |=> pulse_out_pin)
    else $error("pin not high after match A");
  a_pin_low_b: assert property (match_b && os_b == TSTP_OS_LOW |=> !pulse_out_pin)
    else $error("pin not low after match B");
  a_trig_starts: assert property (trig_evt && ctl1_reg.trig_en |=> running)
    else $error("trigger did not start counting");
  a_pin_gate: assert property (!port_reg[TSTP_PORT_TRIG_BIT] |-> !trig_evt)
    else $error("trigger seen while pin is a general port");
  a_halt_holds: assert property (ctl1_reg.trig_en && !run_reg && cnt_reg == 8'h00 && !trig_evt && !wr_cnt
                                 && ctl0_reg.cclr != TSTP_CCLR_ON_TRIG |=> cnt_reg == 8'h00)
    else $error("halted counter moved");
  a_halt_on_clear: assert property (ctl1_reg.trig_en && clr_by_match && !trig_evt |=> !run_reg)
    else $error("clearing match did not halt counting");
  a_count_step: assert property (cnt_inc && !clr_evt && !wr_cnt |=> cnt_reg == $past(cnt_reg) + 8'h01)
    else $error("counter did not step by one");
  a_no_tick_hold: assert property (!tick && !clr_evt && !wr_cnt |=> $stable(cnt_reg))
    else $error("counter moved without a tick");
  a_flag_a_set: assert property (match_a |=> match_a_flag)
    else $error("match A flag not set");
  a_flag_b_set: assert property (match_b |=> match_b_flag)
    else $error("match B flag not set");
  a_count_write: assert property (wr_cnt |=> cnt_reg == $past(wbyte))
    else $error("counter write did not land");
  a_trig_clear: assert property (ctl0_reg.cclr == TSTP_CCLR_ON_TRIG && trig_evt && !wr_cnt
                                 |=> cnt_reg == 8'h00)
    else $error("trigger edge did not clear counter");

endmodule : tstp_top
`default_nettype wire

// file: bench/tstp_far_side.sv
// Purpose: Far-side model that drives the trigger and external clock pins and times the pulse output.
// Assumes: The trigger pin idles high and falls to trigger; the external clock idles low.
// Notes: Cycle stamps are hclk counts kept by the model.
`timescale 1ns/1ps
`default_nettype none
module tstp_far_side (
  input wire logic hclk,
  input wire logic pulse_out_pin,
  output logic trigger_in_pin,
  output logic ext_clk_pin
);
  int unsigned cyc = 0;
  int unsigned trig_at = 0;
  int unsigned rise_at = 0;
  int unsigned fall_at = 0;
  int unsigned n_fall = 0;
  logic last_pin = 1'b0;

  initial begin
    trigger_in_pin = 1'b1;
    ext_clk_pin = 1'b0;
  end

  // Stamps each edge of the pulse output.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    last_pin <= pulse_out_pin;
    if (pulse_out_pin === 1'b1 && last_pin === 1'b0) begin
      rise_at <= cyc;
    end
    if (pulse_out_pin === 1'b0 && last_pin === 1'b1) begin
      fall_at <= cyc;
      n_fall <= n_fall + 1;
    end
  end

  // Gives one falling trigger edge, held low long enough to pass the synchroniser.
  task automatic fire_fall();
    @(posedge hclk);
    trigger_in_pin <= 1'b0;
    trig_at = cyc;
    repeat (8) @(posedge hclk);
    trigger_in_pin <= 1'b1;
  endtask : fire_fall

  // Gives n external clock periods; the clock stands still afterwards.
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge hclk);
      ext_clk_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_clk_pin <= 1'b0;
    end
  endtask : ext_pulses
endmodule : tstp_far_side
`default_nettype wire

// file: bench/trigger_start_pulse_timer_bench.sv
// Purpose: Self-checking bench for the trigger start pulse timer.
// Assumes: Zero-wait AHB-Lite slave; bus signals change just after rising edges.
// Notes: Pulse timing is measured by the far-side model.
`timescale 1ns/1ps
`default_nettype none
module trigger_start_pulse_timer_bench;
  import tstp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic trigger_in_pin;
  logic ext_clk_pin;
  logic pulse_out_pin;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  tstp_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trigger_in_pin(trigger_in_pin),
    .ext_clk_pin(ext_clk_pin), .pulse_out_pin(pulse_out_pin));

  tstp_far_side far (.hclk(hclk), .pulse_out_pin(pulse_out_pin), .trigger_in_pin(trigger_in_pin),
    .ext_clk_pin(ext_clk_pin));

  initial begin
    forever #5 hclk = ~hclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // Cuts a hang short.
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      complete_run();
    end
  end

  // One single-word transfer: address phase, then data phase, each ended by hready.
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                      output logic [31:0] got);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    got = hrdata;
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    logic [31:0] dummy;
    xfer(1'b1, idx, wd, dummy);
  endtask : wr

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_reg(input string name, input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] got;
    xfer(1'b0, idx, 8'h00, got);
    chk(name, {24'h0, exp}, got);
  endtask : chk_reg

  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_rng

  task automatic wait_fall(input int k);
    for (int i = 0; i < 20000 && far.n_fall == k; i++) begin
      @(posedge hclk);
    end
    chk("pulse ended", k + 1, far.n_fall);
  endtask : wait_fall

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    chk("pin after reset", 32'h0, {31'h0, pulse_out_pin});
    chk("ready after reset", 32'h1, {31'h0, hreadyout});
    chk("okay response", 32'h0, {31'h0, hresp});
    chk_reg("ctl0 reset", TSTP_IDX_CTL0, TSTP_CTL0_RST);
    chk_reg("status reset", TSTP_IDX_STAT, TSTP_STAT_RST);
    chk_reg("const a reset", TSTP_IDX_CORA, TSTP_CORA_RST);
    chk_reg("const b reset", TSTP_IDX_CORB, TSTP_CORB_RST);
    chk_reg("counter reset", TSTP_IDX_CNT, TSTP_CNT_RST);
    chk_reg("ctl1 reset", TSTP_IDX_CTL1, TSTP_CTL1_RST);
    chk_reg("port reset", TSTP_IDX_PORT, TSTP_PORT_RST);
    $display("test reset values done");

    wr(TSTP_IDX_CTL1, 8'hff);
    chk_reg("ctl1 mask", TSTP_IDX_CTL1, TSTP_CTL1_WMASK);
    wr(TSTP_IDX_STAT, 8'hff);
    chk_reg("status mask", TSTP_IDX_STAT, TSTP_STAT_WMASK);
    wr(16'hffa6, 8'h55);
    chk_reg("unmapped read", 16'hffa6, 8'h00);
    wr(TSTP_IDX_PORT, 8'h80);
    chk_reg("port bit", TSTP_IDX_PORT, 8'h80);
    $display("test access kinds done");

    wr(TSTP_IDX_CTL1, 8'h00);
    wr(TSTP_IDX_PORT, 8'h00);
    wr(TSTP_IDX_STAT, 8'h00);
    wr(TSTP_IDX_CNT, 8'h00);
    wr(TSTP_IDX_CTL0, 8'h05);
    far.ext_pulses(5);
    repeat (6) @(posedge hclk);
    chk_reg("ext clock count", TSTP_IDX_CNT, 8'h05);
    wr(TSTP_IDX_CNT, 8'hff);
    far.ext_pulses(1);
    repeat (6) @(posedge hclk);
    chk_reg("counter wrap", TSTP_IDX_CNT, 8'h00);
    chk_reg("wrap flags", TSTP_IDX_STAT, 8'he0);
    $display("test external clock done");

    wr(TSTP_IDX_CTL0, 8'h00);
    wr(TSTP_IDX_CNT, 8'h00);
    wr(TSTP_IDX_CORA, 8'hc8);
    wr(TSTP_IDX_CORB, 8'hfa);
    wr(TSTP_IDX_STAT, 8'h16);
    wr(TSTP_IDX_CTL1, 8'hf6);
    wr(TSTP_IDX_CTL0, 8'h13);
    far.fire_fall();
    repeat (300) @(posedge hclk);
    chk_reg("no trigger routed", TSTP_IDX_CNT, 8'h00);
    $display("test unrouted trigger done");

    wr(TSTP_IDX_PORT, 8'h80);
    far.fire_fall();
    wait_fall(0);
    chk_rng("delay to rise", 199 * 64, 200 * 64 + 12, far.rise_at - far.trig_at);
    chk("pulse width", 32'd3200, far.fall_at - far.rise_at);
    chk("pin after b", 32'h0, {31'h0, pulse_out_pin});
    chk_reg("ctl0 readback", TSTP_IDX_CTL0, 8'h13);
    chk_reg("ctl1 readback", TSTP_IDX_CTL1, 8'h14);
    chk_reg("match flags", TSTP_IDX_STAT, 8'hc6);
    repeat (400) @(posedge hclk);
    chk_reg("counter halted", TSTP_IDX_CNT, 8'h00);
    $display("test trigger pulse divide 64 done");

    wr(TSTP_IDX_STAT, 8'h16);
    chk_reg("flags cleared", TSTP_IDX_STAT, 8'h06);
    wr(TSTP_IDX_CTL0, 8'h11);
    far.fire_fall();
    wait_fall(1);
    chk("restart width", 32'd200, far.fall_at - far.rise_at);
    chk_rng("restart delay", 199 * 4, 200 * 4 + 12, far.rise_at - far.trig_at);
    $display("test restart divide 4 done");
    complete_run();
  end
endmodule : trigger_start_pulse_timer_bench
`default_nettype wire
